// ### rtl/ensg_defs.svh
`ifndef ENSG_DEFS_SVH
`define ENSG_DEFS_SVH

// register map, byte addresses on the avalon slave
`define ENSG_ENV_IDX_LSB 4
`define ENSG_OFS_TIMES 4'h0
`define ENSG_OFS_SHAPE 4'h4
`define ENSG_OFS_STATUS 4'h8

// field positions in the times word
`define ENSG_ATK_LSB 0
`define ENSG_DEC_LSB 8
`define ENSG_REL_LSB 16
`define ENSG_SUSL_LSB 24
// field positions in the shape word
`define ENSG_SLOPE_LSB 0
`define ENSG_LOOP_LSB 8
`define ENSG_STIME_LSB 16

// reset values of the per-envelope settings
`define ENSG_RST_ATK 7'h10
`define ENSG_RST_DEC 7'h20
`define ENSG_RST_REL 7'h20
`define ENSG_RST_SUSL 7'h60
`define ENSG_RST_SLOPE 8'h00
`define ENSG_RST_LOOP 7'h00
`define ENSG_RST_STIME 7'h7f

// special codes
`define ENSG_LOOP_OFF 7'h00
`define ENSG_LOOP_INF 7'h7f
`define ENSG_STIME_INF 7'h7f
`define ENSG_FULL 24'hff_ffff

// timing: one envelope sample per sample period
`define ENSG_CLK_PERIOD_NS 10
`define ENSG_SAMPLE_PERIOD_NS 20_833
`define ENSG_TICK_CYCLES (`ENSG_SAMPLE_PERIOD_NS / `ENSG_CLK_PERIOD_NS)

`endif

// ### rtl/ensg_pkg.sv
package ensg_pkg;

  // phase of one envelope
  typedef enum logic [2:0] {
    ph_idle,
    ph_attack,
    ph_decay,
    ph_sustain,
    ph_release
  } ensg_phase_t;

  // software settings of one envelope
  typedef struct packed {
    logic [6:0] attack;
    logic [6:0] decay;
    logic [6:0] rel_time;
    logic [6:0] sus_level;
    logic signed [7:0] slope;
    logic [6:0] loop_cnt;
    logic [6:0] sus_time;
  } ensg_cfg_t;

  // settings plus running state of one envelope
  typedef struct packed {
    ensg_cfg_t cfg;
    ensg_phase_t phase;
    logic [23:0] acc;
    logic [6:0] loops_left;
    logic [15:0] sus_cnt;
  } ensg_env_t;

endpackage

// ### rtl/ensg_tick.sv
`include "ensg_defs.svh"

module ensg_tick #(
  parameter int TICK_CYCLES = `ENSG_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic tick
);

  // prescaler state: cycle count and the registered strobe
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } ensg_tick_t;

  ensg_tick_t st;
  ensg_tick_t next_st;

  ////////////////////////////////////////////////////////////////////////
  // count clocks, pulse once per sample period
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 16'(TICK_CYCLES - 1)) begin
      next_st.cnt = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
    if (!rst_b) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign tick = st.tick;

endmodule

// ### rtl/ensg_step.sv
module ensg_step #(
  parameter int BASE_SHIFT = 20
) (
  input wire logic [6:0] time_code,
  output logic [23:0] step
);

  // exponential map: low three bits pick a mantissa, high four an octave
  logic [3:0] mant;

  always_comb begin
    mant = 4'h8 + {1'b0, ~time_code[2:0]};
    // code 0 spans two samples, code 127 tens of thousands
    step = {20'h0_0000, mant} << (BASE_SHIFT - int'(time_code[6:3]));
  end

endmodule

// ### rtl/ensg_envgen.sv
// Notes on behaviour
// - gate on: ramp zero to full, attack time
// - then fall to sustain level, decay time
// - gate held: stay in sustain from level
// - gate off: fall to zero, release time
// - zero slope holds sustain level constant
// - positive slope rises, larger is faster
// - negative slope falls, larger is faster
// - attack/decay loop: off, 1..126, endless
// - sustain time 127 means unlimited sustain
// - finite sustain time ends in release
// - three independent envelopes per voice
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`include "ensg_defs.svh"

module ensg_envgen #(
  parameter int ENSG_N = 3,
  parameter int TICK_CYCLES = `ENSG_TICK_CYCLES,
  parameter int STEP_SHIFT = 20,
  parameter int SLOPE_SHIFT = 4,
  parameter int SUS_SHIFT = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic key_gate,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [ENSG_N*16-1:0] env_level
);

  ////////////////////////////////////////////////////////////////////////
  // state of the whole block

  typedef struct packed {
    ensg_pkg::ensg_env_t [ENSG_N-1:0] env; // one record per envelope
    logic gate;                             // gate seen last cycle
    logic waitrequest;                      // bus stall, high when idle
    logic [31:0] readdata;                  // registered read answer
  } ensg_top_t;

  ensg_top_t st;       // registered state
  ensg_top_t next_st;  // value for the next edge

  logic sample_tick;   // one pulse per envelope sample

  logic [23:0] atk_step [ENSG_N];  // per-sample rise in attack
  logic [23:0] dec_step [ENSG_N];  // per-sample fall in decay
  logic [23:0] rel_step [ENSG_N];  // per-sample fall in release

  ////////////////////////////////////////////////////////////////////////
  // shared sample-rate prescaler

  ensg_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .tick(sample_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // time codes to step sizes, three per envelope

  for (genvar g = 0; g < ENSG_N; g++) begin : g_steps
    ensg_step #(
      .BASE_SHIFT(STEP_SHIFT)
    ) u_atk (
      .time_code(st.env[g].cfg.attack),
      .step(atk_step[g])
    );
    ensg_step #(
      .BASE_SHIFT(STEP_SHIFT)
    ) u_dec (
      .time_code(st.env[g].cfg.decay),
      .step(dec_step[g])
    );
    ensg_step #(
      .BASE_SHIFT(STEP_SHIFT)
    ) u_rel (
      .time_code(st.env[g].cfg.rel_time),
      .step(rel_step[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // merge a bus write into an old word under the byte enables
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_word,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // sustain level stretched to the accumulator width
  function automatic logic [23:0] level_of(input logic [6:0] lvl);
    return {lvl, lvl, lvl, lvl[6:4]};
  endfunction

  // times word as software sees it
  function automatic logic [31:0] times_word(input ensg_pkg::ensg_cfg_t c);
    return {1'b0, c.sus_level, 1'b0, c.rel_time, 1'b0, c.decay, 1'b0, c.attack};
  endfunction

  // shape word as software sees it
  function automatic logic [31:0] shape_word(input ensg_pkg::ensg_cfg_t c);
    return {9'h000, c.sus_time, 1'b0, c.loop_cnt, c.slope};
  endfunction

  // read decode; unmapped addresses answer zero
  function automatic logic [31:0] rd_word(
    input ensg_top_t s,
    input logic [7:0] a
  );
    logic [31:0] res;
    res = 32'h0000_0000;
    for (int i = 0; i < ENSG_N; i++) begin
      if (a[7:`ENSG_ENV_IDX_LSB] == 4'(i)) begin
        unique case (a[3:0])
          `ENSG_OFS_TIMES: res = times_word(s.env[i].cfg);
          `ENSG_OFS_SHAPE: res = shape_word(s.env[i].cfg);
          `ENSG_OFS_STATUS: begin
            // level, loops still to run, phase
            res = {s.env[i].acc[23:8], 1'b0, s.env[i].loops_left, 5'h00,
                   s.env[i].phase};
          end
          default: res = 32'h0000_0000;
        endcase
      end
    end
    return res;
  endfunction

  // reset image of the whole block
  function automatic ensg_top_t reset_state();
    ensg_top_t r;
    r = '0;
    r.waitrequest = 1'b1;
    for (int i = 0; i < ENSG_N; i++) begin
      r.env[i].phase = ensg_pkg::ph_idle;
      r.env[i].cfg.attack = `ENSG_RST_ATK;
      r.env[i].cfg.decay = `ENSG_RST_DEC;
      r.env[i].cfg.rel_time = `ENSG_RST_REL;
      r.env[i].cfg.sus_level = `ENSG_RST_SUSL;
      r.env[i].cfg.slope = `ENSG_RST_SLOPE;
      r.env[i].cfg.loop_cnt = `ENSG_RST_LOOP;
      r.env[i].cfg.sus_time = `ENSG_RST_STIME;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic: bus slave and envelope engines

  always_comb begin
    logic rise;
    logic fall;
    logic [24:0] sum;
    logic [23:0] tgt;
    logic [23:0] mag;
    logic [15:0] dur;
    logic [31:0] word;
    rise = 1'b0;
    fall = 1'b0;
    sum = 25'h000_0000;
    tgt = 24'h00_0000;
    mag = 24'h00_0000;
    dur = 16'h0000;
    word = 32'h0000_0000;
    next_st = st;
    next_st.gate = key_gate;
    rise = key_gate & ~st.gate;
    fall = ~key_gate & st.gate;

    // bus: one wait state, then the access completes
    if (st.waitrequest && (avs_read || avs_write)) begin
      next_st.waitrequest = 1'b0;
      next_st.readdata = rd_word(st, avs_address);
    end else if (!st.waitrequest) begin
      // the master samples low at this edge; stall again after it
      next_st.waitrequest = 1'b1;
    end

    for (int i = 0; i < ENSG_N; i++) begin
      tgt = level_of(st.env[i].cfg.sus_level);
      if (rise) begin
        // retrigger from zero whatever phase was active
        next_st.env[i].phase = ensg_pkg::ph_attack;
        next_st.env[i].acc = 24'h00_0000;
        next_st.env[i].loops_left = st.env[i].cfg.loop_cnt;
        next_st.env[i].sus_cnt = 16'h0000;
      end else if (fall && st.env[i].phase != ensg_pkg::ph_idle) begin
        // key up: fade out from wherever the level stands
        next_st.env[i].phase = ensg_pkg::ph_release;
      end else if (sample_tick) begin
        unique case (st.env[i].phase)
          ensg_pkg::ph_idle: begin
            next_st.env[i].acc = 24'h00_0000;
          end
          ensg_pkg::ph_attack: begin
            sum = {1'b0, st.env[i].acc} + {1'b0, atk_step[i]};
            if (sum >= {1'b0, `ENSG_FULL}) begin
              next_st.env[i].acc = `ENSG_FULL;
              next_st.env[i].phase = ensg_pkg::ph_decay;
            end else begin
              next_st.env[i].acc = sum[23:0];
            end
          end
          ensg_pkg::ph_decay: begin
            sum = {1'b0, tgt} + {1'b0, dec_step[i]};
            if ({1'b0, st.env[i].acc} <= sum) begin
              next_st.env[i].acc = tgt;
              if (st.env[i].cfg.loop_cnt == `ENSG_LOOP_INF) begin
                next_st.env[i].phase = ensg_pkg::ph_attack;
              end else if (st.env[i].loops_left != `ENSG_LOOP_OFF) begin
                next_st.env[i].loops_left = st.env[i].loops_left - 7'h01;
                next_st.env[i].phase = ensg_pkg::ph_attack;
              end else begin
                // sustain starts exactly at the programmed level
                next_st.env[i].phase = ensg_pkg::ph_sustain;
                next_st.env[i].sus_cnt = 16'h0000;
              end
            end else begin
              next_st.env[i].acc = st.env[i].acc - dec_step[i];
            end
          end
          ensg_pkg::ph_sustain: begin
            // slope magnitude; the most negative code still fits 8 bits
            if (st.env[i].cfg.slope < 0) begin
              mag = {16'h0000, 8'(-st.env[i].cfg.slope)} << SLOPE_SHIFT;
            end else begin
              mag = {16'h0000, st.env[i].cfg.slope} << SLOPE_SHIFT;
            end
            if (st.env[i].cfg.slope > 0) begin
              sum = {1'b0, st.env[i].acc} + {1'b0, mag};
              if (sum >= {1'b0, `ENSG_FULL}) begin
                next_st.env[i].acc = `ENSG_FULL;
              end else begin
                next_st.env[i].acc = sum[23:0];
              end
            end else if (st.env[i].cfg.slope < 0) begin
              if (st.env[i].acc <= mag) begin
                next_st.env[i].acc = 24'h00_0000;
              end else begin
                next_st.env[i].acc = st.env[i].acc - mag;
              end
            end else begin
              // flat sustain: level untouched
              next_st.env[i].acc = st.env[i].acc;
            end
            // finite sustain time counts samples; 127 never times out
            dur = ({9'h000, st.env[i].cfg.sus_time} + 16'h0001) << SUS_SHIFT;
            if (st.env[i].cfg.sus_time != `ENSG_STIME_INF) begin
              if (st.env[i].sus_cnt >= dur - 16'h0001) begin
                next_st.env[i].phase = ensg_pkg::ph_release;
              end else begin
                next_st.env[i].sus_cnt = st.env[i].sus_cnt + 16'h0001;
              end
            end
          end
          ensg_pkg::ph_release: begin
            if (st.env[i].acc <= rel_step[i]) begin
              next_st.env[i].acc = 24'h00_0000;
              next_st.env[i].phase = ensg_pkg::ph_idle;
            end else begin
              next_st.env[i].acc = st.env[i].acc - rel_step[i];
            end
          end
          default: begin
            // an illegal phase code falls back to rest
            next_st.env[i].phase = ensg_pkg::ph_idle;
            next_st.env[i].acc = 24'h00_0000;
          end
        endcase
      end

      // settings writes land on the edge where the master samples waitrequest low
      if (avs_write && !st.waitrequest
          && avs_address[7:`ENSG_ENV_IDX_LSB] == 4'(i)) begin
        if (avs_address[3:0] == `ENSG_OFS_TIMES) begin
          word = be_merge(times_word(st.env[i].cfg), avs_writedata,
                          avs_byteenable);
          next_st.env[i].cfg.attack = word[`ENSG_ATK_LSB +: 7];
          next_st.env[i].cfg.decay = word[`ENSG_DEC_LSB +: 7];
          next_st.env[i].cfg.rel_time = word[`ENSG_REL_LSB +: 7];
          next_st.env[i].cfg.sus_level = word[`ENSG_SUSL_LSB +: 7];
        end else if (avs_address[3:0] == `ENSG_OFS_SHAPE) begin
          word = be_merge(shape_word(st.env[i].cfg), avs_writedata,
                          avs_byteenable);
          next_st.env[i].cfg.slope = word[`ENSG_SLOPE_LSB +: 8];
          next_st.env[i].cfg.loop_cnt = word[`ENSG_LOOP_LSB +: 7];
          next_st.env[i].cfg.sus_time = word[`ENSG_STIME_LSB +: 7];
        end
      end
    end

    // synchronous reset wins over everything
    if (!rst_b) begin
      next_st = reset_state();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // the only register process

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from state flops

  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitrequest;

  for (genvar g = 0; g < ENSG_N; g++) begin : g_out
    assign env_level[g*16 +: 16] = st.env[g].acc[23:8];
  end

endmodule

// ### tb/ensg_gate_src.sv
module ensg_gate_src (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic note_on,
  output logic key_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  // key logic: a clean level that only moves on a rising edge, low in reset
  always_ff @(posedge clk) begin
    key_gate <= rst_b & note_on;
  end
endmodule

// ### tb/ensg_envgen_monitor.sv
module ensg_envgen_monitor #(
  parameter int ENSG_N = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic key_gate,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [ENSG_N*16-1:0] env_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic req; // any access pending
  logic rd_req; // read seen by the slave this edge
  assign req = avs_read || avs_write;
  assign rd_req = avs_read && avs_waitrequest;
  //////////////////////////////
  // bus: one wait state, and the answer lasts a single cycle
  a_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!req && avs_waitrequest |=> avs_waitrequest)
    else $error("answer given without a request");
  // read data must not drift between accesses, software may sample late
  a_read_hold: assert property (!(req && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved between accesses");
  a_unmapped_zero: assert property (rd_req && (avs_address[7:4] >= ENSG_N ||
      !(avs_address[3:0] inside {4'h0, 4'h4, 4'h8})) |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_status_fields: assert property (rd_req && avs_address[3:0] == 4'h8 |=>
      avs_readdata[15] == 1'b0 && avs_readdata[7:3] == 5'h00 && avs_readdata[2:0] <= 3'h4)
    else $error("bad status word");
  a_shape_resv: assert property (rd_req && avs_address[3:0] == 4'h4 |=>
      avs_readdata[31:23] == 9'h000)
    else $error("shape reserved bits set");
  //////////////////////////////
  // envelope: a gate rise clears every level within a few cycles
  a_restart_zero: assert property ($rose(key_gate) |-> ##[1:3] env_level == '0)
    else $error("no restart from zero on gate rise");
  a_idle_zero: assert property (!key_gate && !$past(key_gate) && env_level == '0 |=>
      env_level == '0)
    else $error("level rose without a gate");
endmodule

bind ensg_envgen ensg_envgen_monitor #(.ENSG_N(ENSG_N)) ensg_envgen_monitor_i (
  .clk(clk), .rst_b(rst_b), .key_gate(key_gate), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .env_level(env_level));

// ### tb/ensg_envgen_tb.sv
`include "ensg_defs.svh"
module ensg_envgen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TCK = 8; // short sample period keeps the run brief
  localparam int FULL = 32'h00ff_ffff;
  logic clk, rst_b, note_on, key_gate, full;
  logic avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, d, m, e, t0;
  logic [3:0] be;
  logic [3:0] avs_byteenable;
  logic [47:0] env_level;
  int n_mismatch, tests_run, cnt, v;
  int ac[3];
  int sl[4] = '{16, 64, -16, -64}; // slow then fast, both signs
  int lp[3] = '{0, 2, 5}; // loop counts: off and finite
  //////////////////////////////
  ensg_gate_src ensg_gate_src_i (.clk(clk), .rst_b(rst_b), .note_on(note_on),
    .key_gate(key_gate));
  ensg_envgen #(.TICK_CYCLES(TCK), .SUS_SHIFT(1)) ensg_envgen_i (.clk(clk), .rst_b(rst_b),
    .key_gate(key_gate), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .env_level(env_level));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////
  // model: accumulator step per tick for a time code
  function automatic int stp(int c);
    return (15 - (c & 7)) << (20 - (c >> 3));
  endfunction
  function automatic logic [15:0] lvl(int g);
    return env_level[g*16 +: 16];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one access; held until waitrequest is sampled low, the only edge that counts
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      input logic [3:0] b);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= b;
    avs_write <= wr;
    avs_read <= !wr;
    // look at the slave mid-cycle, where its registered outputs have settled
    do begin
      @(negedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    check(n < 50, 1);
    q = avs_readdata;
    // the edge that samples waitrequest low completes the access
    @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ticks(int k);
    repeat (k * TCK) @(posedge clk);
  endtask
  task automatic gate(logic g);
    note_on <= g;
    repeat (4) @(posedge clk);
  endtask
  // polls status, bounded, so a stuck phase fails instead of hanging
  task automatic wait_phase(int g, logic [2:0] ph);
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'(g * 16 + 8), 32'h0000_0000, 4'hf);
      n++;
    end while (q[2:0] !== ph && n < 3000);
    check(q[2:0], ph);
  endtask
  // every level change during attack must match the model's next sample
  task automatic watch_attack(int g, int c);
    int acc, n;
    logic [15:0] prev;
    acc = 0;
    while (acc < FULL) begin
      prev = 16'(acc >> 8);
      acc = (acc + stp(c) > FULL) ? FULL : acc + stp(c);
      n = 0;
      while (lvl(g) === prev && n < 100 * TCK) begin
        @(posedge clk);
        n++;
      end
      check(lvl(g), acc >> 8);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end
  //////////////////////////////
  initial begin
    void'($urandom(43547));
    {rst_b, note_on, avs_read, avs_write} = 4'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // defaults, reserved bits and byte lane merge
    for (int g = 0; g < 3; g++) begin
      e = {1'b0, `ENSG_RST_SUSL, 1'b0, `ENSG_RST_REL, 1'b0, `ENSG_RST_DEC, 1'b0, `ENSG_RST_ATK};
      bus(1'b0, 8'(g * 16), 32'h0000_0000, 4'hf);
      check(q, e);
      bus(1'b0, 8'(g * 16 + 4), 32'h0000_0000, 4'hf);
      check(q, {9'h000, `ENSG_RST_STIME, 1'b0, `ENSG_RST_LOOP, `ENSG_RST_SLOPE});
      bus(1'b0, 8'(g * 16 + 8), 32'h0000_0000, 4'hf);
      check(q, 32'h0000_0000);
      d = $urandom();
      be = 4'($urandom_range(1, 15));
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      e = ((e & ~m) | (d & m)) & 32'h7f7f_7f7f;
      if (g == 0) t0 = e;
      bus(1'b1, 8'(g * 16), d, be);
      bus(1'b0, 8'(g * 16), 32'h0000_0000, 4'hf);
      check(q, e);
    end
    // an index past the last envelope must not alias onto envelope zero
    bus(1'b1, 8'h30, 32'h0000_0000, 4'hf);
    bus(1'b0, 8'h30, 32'h0000_0000, 4'hf);
    check(q, 32'h0000_0000);
    bus(1'b0, 8'h0c, 32'h0000_0000, 4'hf);
    check(q, 32'h0000_0000);
    bus(1'b0, 8'h00, 32'h0000_0000, 4'hf);
    check(q, t0);
    $display("test registers done");
    for (int g = 0; g < 3; g++) begin
      ac[g] = $urandom_range(32, 63);
      bus(1'b1, 8'(g * 16), {8'h40, 8'h50, 8'h30, 8'(ac[g])}, 4'hf);
      bus(1'b1, 8'(g * 16 + 4), 32'h007f_0000, 4'hf);
    end
    gate(1'b1);
    fork
      watch_attack(0, ac[0]);
      watch_attack(1, ac[1]);
      watch_attack(2, ac[2]);
    join
    wait_phase(0, 3'h3);
    v = lvl(0);
    check(v < 32'h0000_ffff, 1);
    ticks(20);
    check(lvl(0), v);
    $display("test attack done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h04, {16'h007f, 8'h00, 8'(sl[i])}, 4'hf);
      ticks(1);
      v = lvl(0);
      ticks(10);
      check(lvl(0), v + sl[i] * 10 / 16);
    end
    gate(1'b0);
    v = lvl(0);
    ticks(2);
    check(lvl(0), v - 120);
    wait_phase(0, 3'h0);
    check(lvl(0), 0);
    $display("test slope and release done");
    for (int g = 0; g < 3; g++) begin
      bus(1'b1, 8'(g * 16), 32'h4050_0000, 4'hf);
      bus(1'b1, 8'(g * 16 + 4), (g == 0) ? 32'h0003_0000 : 32'h007f_0000, 4'hf);
    end
    gate(1'b1);
    wait_phase(0, 3'h3);
    ticks(4);
    bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
    check(q[2:0], 3'h3);
    ticks(6);
    bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
    check(q[2:0], 3'h4);
    bus(1'b0, 8'h18, 32'h0000_0000, 4'hf);
    check(q[2:0], 3'h3);
    gate(1'b0);
    wait_phase(0, 3'h0);
    wait_phase(1, 3'h0);
    $display("test sustain time done");
    bus(1'b1, 8'h00, 32'h4020_3030, 4'hf);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h04, {8'h00, 8'h7f, 1'b0, 7'(lp[i]), 8'h00}, 4'hf);
      gate(1'b1);
      cnt = 0;
      full = 1'b0;
      fork
        wait_phase(0, 3'h3);
        forever begin
          @(posedge clk);
          if (lvl(0) === 16'hffff && !full) cnt++;
          full = (lvl(0) === 16'hffff);
        end
      join_any
      disable fork;
      check(cnt, lp[i] + 1);
      gate(1'b0);
      gate(1'b1);
      bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
      check(q[14:0], {7'(lp[i]), 8'h01});
      gate(1'b0);
      wait_phase(0, 3'h0);
    end
    bus(1'b1, 8'h04, 32'h007f_7f00, 4'hf);
    gate(1'b1);
    ticks(300);
    bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
    check(q[2:0] inside {3'h1, 3'h2}, 1);
    gate(1'b0);
    wait_phase(0, 3'h0);
    $display("test loops done");
    stop_test();
  end
endmodule
